// File: logic/sbc_pkg.sv
// Purpose: Constants and types for the serial BCD clock/calendar with byte storage.
// Assumes: 20 MHz core clock; two-wire bus sampled by that clock.
// Notes:   Overview of operation below; every count derives from a time and the rate.
// Overview of operation
// - START plus matching slave address gains access
// - Sixty-four bytes: time, date, control, then storage
// - Byte pointer advances after every data byte
// - First seven bytes are BCD clock/calendar
// - Supply loss aborts access, clears byte pointer
// - Bus inputs ignored while supply is low
// - Century flag toggles per century when enabled
// - Byte two: enable, flag, 24-hour BCD hours
// - Byte seven: level, test select, calibration fields
// - Counters keep their BCD ranges, ignore unused bits
// - February gains a day in leap years
// - Data changes while clock high are conditions
// - Data falling with clock high is START
// - Data rising with clock high is STOP
// - One clock per bit, change while low
// - Serve unlimited bytes until STOP arrives
// - Receiver acknowledges on the ninth clock
// - Inputs low-pass filtered, 250 to 1000 ns
// - Device holds data low through acknowledge high
// - Master not acknowledging ends read, line released
package sbc_pkg;
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          CLK_NS      = 50;
    localparam int          LPF_NS      = 500;
    localparam int          LPF_CYC     = (LPF_NS + CLK_NS - 1) / CLK_NS;
    localparam int          SEC_CYC     = CLK_HZ;
    localparam int          TEST_HZ     = 512;
    localparam int          TEST_HALF_CYC = CLK_HZ / (2 * TEST_HZ);
    localparam logic [7:0]  SLAVE_ADDR  = 8'hD0;
    localparam int          MEM_DEPTH   = 64;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          FIFO_WIDTH  = 14;
    localparam logic [5:0]  A_SEC       = 6'h00;
    localparam logic [5:0]  A_MIN       = 6'h01;
    localparam logic [5:0]  A_HOUR      = 6'h02;
    localparam logic [5:0]  A_WDAY      = 6'h03;
    localparam logic [5:0]  A_DATE      = 6'h04;
    localparam logic [5:0]  A_MON       = 6'h05;
    localparam logic [5:0]  A_YEAR      = 6'h06;
    localparam logic [5:0]  A_CTRL      = 6'h07;
    localparam int          B_HALT      = 7;
    localparam int          B_CEN_EN    = 7;
    localparam int          B_CEN_FLAG  = 6;
    localparam int          B_OUT_LVL   = 7;
    localparam int          B_TEST_SEL  = 6;
    localparam logic [7:0]  RST_WDAY    = 8'h01;
    localparam logic [7:0]  RST_DATE    = 8'h01;
    localparam logic [7:0]  RST_MON     = 8'h01;
    localparam logic [7:0]  RST_CTRL    = 8'h80;
    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_PTR, PH_WR, PH_ACK, PH_RD, PH_RD_ACK
    } sbc_state_e;
endpackage

// File: logic/sbc_top.sv
// Purpose: Two-wire bus slave clock/calendar with 56 bytes of byte storage.
// Assumes: Bus pins and supply sense are asynchronous; open-drain pins resolved outside.
// Notes:   Calibration fields are stored but do not trim the timebase.
`timescale 1ns/10ps
`default_nettype none

module sbc_deglitch (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Pin side
    input  wire logic raw_i,
    // Filtered level
    output logic      level_o
);
    import sbc_pkg::*;
    logic       sync1;
    logic       sync2;
    logic [4:0] run;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= raw_i;
            sync2 <= sync1;
        end
    end

    // Level must hold LPF_CYC cycles before it is believed
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run     <= 5'h00;
            level_o <= 1'b1;
        end else if (sync2 == level_o) begin
            run <= 5'h00;
        end else if (run == 5'(LPF_CYC - 1)) begin
            run     <= 5'h00;
            level_o <= sync2;
        end else begin
            run <= run + 5'h01;
        end
    end
endmodule

module sbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             do_wr;
    logic             do_rd;

    assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o  = store[rd_ptr[AW-1:0]];
    assign do_wr       = in_valid_i && in_ready_o;
    assign do_rd       = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (do_wr) begin
            store[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule

module sbc_top #(
    parameter int SEC_CYCLES  = sbc_pkg::SEC_CYC,
    parameter int TEST_HALF   = sbc_pkg::TEST_HALF_CYC
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Two-wire bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // Supply sense, high while above the battery_switch_threshold
    input  wire logic power_good_i,
    // Open-drain test_or_level_pin
    output logic      test_pin_o,
    output logic      test_pin_oe_o
);
    import sbc_pkg::*;

    logic              scl_f;
    logic              sda_f;
    logic              scl_q;
    logic              sda_q;
    logic              pwr_s1;
    logic              pwr_ok;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_ev;
    logic              stop_ev;
    sbc_state_e        state;
    logic [3:0]        bit_cnt;
    logic [7:0]        shift;
    logic [7:0]        tx;
    logic              dir_rd;
    logic              got_ptr;
    logic [5:0]        ptr;
    logic              push_valid;
    logic [13:0]       push_data;
    logic              push_ready;
    logic              pop_valid;
    logic [13:0]       pop_data;
    logic [7:0]        mem [MEM_DEPTH];
    logic [24:0]       sec_div;
    logic              tick;
    logic [15:0]       test_div;
    logic              test_sq;
    logic [8:0]        next_sec;
    logic [8:0]        next_min;
    logic [8:0]        next_hour;
    logic [8:0]        next_wday;
    logic [8:0]        next_date;
    logic [8:0]        next_mon;
    logic [8:0]        next_year;
    logic [7:0]        last_day;
    logic              leap;
    logic              c_min;
    logic              c_hour;
    logic              c_day;
    logic              c_mon;
    logic              c_year;
    logic              c_cen;

    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] hi,
                                            input logic [7:0] lo);
        if (v >= hi) begin
            bcd_step = {1'b1, lo};
        end else if (v[3:0] == 4'h9) begin
            bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_step = {1'b0, v + 8'h01};
        end
    endfunction

    sbc_deglitch u_scl (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .raw_i      (scl_i),
        .level_o    (scl_f)
    );
    sbc_deglitch u_sda (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .raw_i      (sda_i),
        .level_o    (sda_f)
    );

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_s1 <= 1'b0;
            pwr_ok <= 1'b0;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end else begin
            pwr_s1 <= power_good_i;
            pwr_ok <= pwr_s1;
            scl_q  <= scl_f;
            sda_q  <= sda_f;
        end
    end

    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    assign start_ev = scl_f && scl_q && sda_q && !sda_f;
    assign stop_ev  = scl_f && scl_q && !sda_q && sda_f;

    // Bus protocol engine
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= PH_IDLE;
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            tx         <= 8'h00;
            dir_rd     <= 1'b0;
            got_ptr    <= 1'b0;
            ptr        <= 6'h00;
            sda_oe_o   <= 1'b0;
            push_valid <= 1'b0;
            push_data  <= 14'h0000;
        end else if (!pwr_ok) begin
            state      <= PH_IDLE;
            ptr        <= 6'h00;
            sda_oe_o   <= 1'b0;
            push_valid <= 1'b0;
        end else begin
            push_valid <= 1'b0;
            if (start_ev) begin
                state    <= PH_ADDR;
                bit_cnt  <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_ev) begin
                state    <= PH_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state)
                    PH_ADDR, PH_PTR, PH_WR: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            if (state == PH_ADDR) begin
                                if (shift[7:1] == SLAVE_ADDR[7:1]) begin
                                    dir_rd   <= shift[0];
                                    got_ptr  <= 1'b0;
                                    sda_oe_o <= 1'b1;
                                    state    <= PH_ACK;
                                end else begin
                                    state <= PH_IDLE;
                                end
                            end else if (state == PH_PTR) begin
                                ptr      <= shift[5:0];
                                got_ptr  <= 1'b1;
                                sda_oe_o <= 1'b1;
                                state    <= PH_ACK;
                            end else if (push_ready) begin
                                push_valid <= 1'b1;
                                push_data  <= {ptr, shift};
                                ptr        <= ptr + 6'h01;
                                sda_oe_o   <= 1'b1;
                                state      <= PH_ACK;
                            end else begin
                                // Storage path backed up: refuse the byte
                                state <= PH_IDLE;
                            end
                        end
                    end
                    PH_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (dir_rd) begin
                                tx       <= {mem[ptr][6:0], 1'b0};
                                sda_oe_o <= !mem[ptr][7];
                                bit_cnt  <= 4'h1;
                                state    <= PH_RD;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state    <= got_ptr ? PH_WR : PH_PTR;
                            end
                        end
                    end
                    PH_RD: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                sda_oe_o <= 1'b0;
                                ptr      <= ptr + 6'h01;
                                state    <= PH_RD_ACK;
                            end else begin
                                sda_oe_o <= !tx[7];
                                tx       <= {tx[6:0], 1'b0};
                                bit_cnt  <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    PH_RD_ACK: begin
                        if (scl_rise) begin
                            // No acknowledge: line stays released for the STOP
                            state <= sda_f ? PH_IDLE : PH_ACK;
                        end
                    end
                    default: begin
                        state <= PH_IDLE;
                    end
                endcase
            end
        end
    end

    // Decouples bus writes from timekeeping updates of the same bytes
    sbc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_valid),
        .in_data_i   (push_data),
        .in_ready_o  (push_ready),
        .out_valid_o (pop_valid),
        .out_data_o  (pop_data),
        .out_ready_i (!tick)
    );

    // Seconds timebase; halt bit freezes it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_div <= 25'h0000000;
            tick    <= 1'b0;
        end else if (mem[A_SEC][B_HALT]) begin
            sec_div <= 25'h0000000;
            tick    <= 1'b0;
        end else begin
            tick    <= sec_div == 25'(SEC_CYCLES - 1);
            sec_div <= (sec_div == 25'(SEC_CYCLES - 1)) ? 25'h0000000 : sec_div + 25'h0000001;
        end
    end

    always_comb begin
        leap      = mem[A_YEAR][4] ? (mem[A_YEAR][3:0] == 4'h2 || mem[A_YEAR][3:0] == 4'h6)
                                   : (mem[A_YEAR][3:0] == 4'h0 || mem[A_YEAR][3:0] == 4'h4
                                      || mem[A_YEAR][3:0] == 4'h8);
        case (mem[A_MON][4:0])
            5'h02: last_day = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
        next_sec  = bcd_step({1'b0, mem[A_SEC][6:0]}, 8'h59, 8'h00);
        next_min  = bcd_step({1'b0, mem[A_MIN][6:0]}, 8'h59, 8'h00);
        next_hour = bcd_step({2'b00, mem[A_HOUR][5:0]}, 8'h23, 8'h00);
        next_wday = bcd_step({5'h00, mem[A_WDAY][2:0]}, 8'h07, 8'h01);
        next_date = bcd_step({2'b00, mem[A_DATE][5:0]}, last_day, 8'h01);
        next_mon  = bcd_step({3'b000, mem[A_MON][4:0]}, 8'h12, 8'h01);
        next_year = bcd_step(mem[A_YEAR], 8'h99, 8'h00);
        c_min     = next_sec[8];
        c_hour    = c_min && next_min[8];
        c_day     = c_hour && next_hour[8];
        c_mon     = c_day && next_date[8];
        c_year    = c_mon && next_mon[8];
        c_cen     = c_year && next_year[8];
    end

    // Byte storage: timekeeping on a tick, otherwise drained bus writes
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
            mem[A_WDAY] <= RST_WDAY;
            mem[A_DATE] <= RST_DATE;
            mem[A_MON]  <= RST_MON;
            mem[A_CTRL] <= RST_CTRL;
        end else if (tick) begin
            mem[A_SEC] <= {mem[A_SEC][B_HALT], next_sec[6:0]};
            if (c_min) begin
                mem[A_MIN] <= {mem[A_MIN][7], next_min[6:0]};
            end
            if (c_hour) begin
                mem[A_HOUR][5:0] <= next_hour[5:0];
            end
            if (c_day) begin
                mem[A_WDAY][2:0] <= next_wday[2:0];
                mem[A_DATE][5:0] <= next_date[5:0];
            end
            if (c_mon) begin
                mem[A_MON][4:0] <= next_mon[4:0];
            end
            if (c_year) begin
                mem[A_YEAR] <= next_year[7:0];
            end
            if (c_cen && mem[A_HOUR][B_CEN_EN]) begin
                mem[A_HOUR][B_CEN_FLAG] <= !mem[A_HOUR][B_CEN_FLAG];
            end
        end else if (pop_valid) begin
            mem[pop_data[13:8]] <= pop_data[7:0];
        end
    end

    // Pin shows the stored level, or a square wave in test mode
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test_div      <= 16'h0000;
            test_sq       <= 1'b0;
            test_pin_o    <= 1'b0;
            test_pin_oe_o <= 1'b0;
            sda_o         <= 1'b0;
        end else begin
            test_div      <= (test_div == 16'(TEST_HALF - 1)) ? 16'h0000 : test_div + 16'h0001;
            test_sq       <= (test_div == 16'(TEST_HALF - 1)) ? !test_sq : test_sq;
            test_pin_oe_o <= mem[A_CTRL][B_TEST_SEL] ? !test_sq : !mem[A_CTRL][B_OUT_LVL];
        end
    end

    default clocking core_edge @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence rx_byte_done_s;
        state == PH_PTR && scl_fall && bit_cnt == 4'h8 && !start_ev && !stop_ev && pwr_ok;
    endsequence
    sequence rd_byte_done_s;
        state == PH_RD && scl_fall && bit_cnt == 4'h8 && !start_ev && !stop_ev && pwr_ok;
    endsequence
    sequence power_low_s;
        !pwr_ok ##1 !pwr_ok;
    endsequence

    start_enters_addr_a: assert property (start_ev && pwr_ok |=> state == PH_ADDR && !sda_oe_o)
        else $error("start not taken");
    stop_ends_xfer_a: assert property (stop_ev && !start_ev && pwr_ok |=> state == PH_IDLE && !sda_oe_o)
        else $error("stop not taken");
    power_abort_a: assert property (!pwr_ok |=> ptr == 6'h00 && state == PH_IDLE)
        else $error("supply loss did not abort");
    power_ignore_a: assert property (power_low_s |-> !sda_oe_o && !push_valid)
        else $error("bus served while supply low");
    addr_mismatch_a: assert property (state == PH_ADDR && scl_fall && bit_cnt == 4'h8 && !start_ev
        && !stop_ev && pwr_ok && shift[7:1] != SLAVE_ADDR[7:1] |=> state == PH_IDLE && !sda_oe_o)
        else $error("foreign address acknowledged");
    rx_ack_drive_a: assert property (rx_byte_done_s |=> sda_oe_o && state == PH_ACK)
        else $error("received byte not acknowledged");
    sda_change_low_a: assert property ($changed(sda_oe_o) && $past(pwr_ok) |-> !$past(scl_f))
        else $error("data driven while clock high");
    read_ptr_step_a: assert property (rd_byte_done_s |=> ptr == $past(ptr) + 6'h01)
        else $error("pointer not advanced after read byte");
    sec_rollover_a: assert property (tick && mem[A_SEC][6:0] == 7'h59 |=> mem[A_SEC][6:0] == 7'h00)
        else $error("seconds did not roll over");
    century_hold_a: assert property (tick && !mem[A_HOUR][B_CEN_EN]
        |=> mem[A_HOUR][B_CEN_FLAG] == $past(mem[A_HOUR][B_CEN_FLAG]))
        else $error("century flag moved while disabled");
    leap_feb_a: assert property (tick && c_day && leap && mem[A_MON] == 8'h02
        && mem[A_DATE] == 8'h28 |=> mem[A_DATE] == 8'h29)
        else $error("leap day skipped");
endmodule

`default_nettype wire

// File: tb/sbc_bus_master.sv
// Purpose: Two-wire bus master model for the clock/calendar device.
// Assumes: Bench resolves open-drain data; only this model drives clock.
// Notes:   Phase of P cycles, well above the device input filter.
`timescale 1ns/10ps
`default_nettype none
module sbc_bus_master #(
    parameter int P = 30
) (
    // Clock
    input  wire logic core_clk_i,
    // Bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic hold();
        repeat (P) @(posedge core_clk_i);
    endtask
    // Data released first, so it also serves as repeated start
    task automatic start();
        sda_oe_o <= 1'b0;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_oe_o <= 1'b1;
        hold();
        scl_o <= 1'b0;
        hold();
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_oe_o <= 1'b0;
        hold();
    endtask
    // Data moves only with clock low, sampled late in high phase
    task automatic bitx(input logic b, output logic s);
        sda_oe_o <= ~b;
        hold();
        scl_o <= 1'b1;
        hold();
        s = sda_i;
        scl_o <= 1'b0;
        hold();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, ack);
    endtask
    // Last byte left unacknowledged to end the read
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, s);
    endtask
endmodule
`default_nettype wire

// File: tb/serial_bcd_clock_calendar_ram_test.sv
// Purpose: Self-checking bench for the serial clock/calendar.
// Assumes: Short second count so calendar carries happen quickly.
// Notes:   Seconds byte ticks, so it is compared only in the storage wrap check, while halted.
`timescale 1ns/10ps
`default_nettype none
module serial_bcd_clock_calendar_ram_test;
    import sbc_pkg::*;
    localparam int SEC = 4000;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       pg = 1'b1;
    wire logic  scl, m_oe, d_oe, t_oe;
    wire logic  sda = ~(m_oe | d_oe);
    int         err_count = 0;
    int         n_compared = 0;
    logic [7:0] got[8];
    logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80};
    logic [7:0] yr[2] = '{8'h96, 8'h99};
    logic [7:0] eh[2] = '{8'hC0, 8'h80};
    logic [7:0] ed[2] = '{8'h29, 8'h01};
    logic [7:0] em[2] = '{8'h02, 8'h01};
    logic [7:0] mo[2] = '{8'h02, 8'h12};
    logic [7:0] da[2] = '{8'h28, 8'h31};
    always #25 core_clk = ~core_clk;
    sbc_top #(.SEC_CYCLES(SEC), .TEST_HALF(8)) dut (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(d_oe), .power_good_i(pg),
        .test_pin_o(), .test_pin_oe_o(t_oe));
    sbc_bus_master m (.core_clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d[8], input int n);
        logic a;
        m.start();
        m.wbyte(8'hD0, a);
        chk({7'h0, a}, 8'h00);
        m.wbyte(p, a);
        for (int i = 0; i < n; i++) m.wbyte(d[i], a);
        m.stop();
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        logic a;
        m.start();
        m.wbyte(8'hD0, a);
        m.wbyte(p, a);
        m.start();
        m.wbyte(8'hD1, a);
        chk({7'h0, a}, 8'h00);
        for (int i = 0; i < n; i++) m.rbyte(i == n - 1, got[i]);
        m.stop();
    endtask
    initial begin
        logic a;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk({7'h0, t_oe}, 8'h00);
        rd(8'h00, 8);
        for (int i = 1; i < 8; i++) chk(got[i], rv[i]);
        $display("reset values done");
        wr(8'hFE, '{8'hA5, 8'h3C, 8'h85, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
        rd(8'h3E, 3);
        chk(got[0], 8'hA5);
        chk(got[1], 8'h3C);
        chk(got[2], 8'h85);
        $display("storage wrap done");
        for (int c = 0; c < 2; c++) begin
            // Second pass is the last second of a century, so every carry ripples
            wr(8'h01, '{8'h59, 8'hE3, 8'h04, da[c], mo[c], yr[c], 8'h00, 8'h00}, 7);
            wr(8'h00, '{8'h59, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
            repeat (SEC + 100) @(posedge core_clk);
            rd(8'h00, 8);
            chk(got[1], 8'h00);
            chk(got[2], eh[c]);
            chk(got[3], 8'h05);
            chk(got[4], ed[c]);
            chk(got[5], em[c]);
            chk(got[6], c ? 8'h00 : 8'h96);
            chk(got[7], 8'h00);
            $display("calendar carry done");
        end
        chk({7'h0, t_oe}, 8'h01);
        wr(8'h07, '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
        a = t_oe;
        // Half period of the test wave is 8 cycles, so the pin must have flipped
        repeat (8) @(posedge core_clk);
        chk({7'h0, t_oe}, {7'h0, ~a});
        $display("test output done");
        m.start();
        m.wbyte(8'hA0, a);
        chk({7'h0, a}, 8'h01);
        m.stop();
        m.start();
        m.wbyte(8'hD0, a);
        m.wbyte(8'h3E, a);
        pg <= 1'b0;
        m.stop();
        m.start();
        m.wbyte(8'hD0, a);
        chk({7'h0, a}, 8'h01);
        m.stop();
        pg <= 1'b1;
        repeat (40) @(posedge core_clk);
        m.start();
        m.wbyte(8'hD1, a);
        m.rbyte(1'b0, got[0]);
        m.rbyte(1'b1, got[1]);
        m.stop();
        chk(got[1], 8'h00);
        $display("address and power done");
        conclude();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
